// *** verilog/adrg_gain_ctl.sv ***
// Dynamic range gain controller with Avalon-MM register slave
// What this block does
// - Gain never drops below the floor chosen by bits 3:2.
// - Gain never rises above the ceiling chosen by bits 1:0.
// - Computed gain is clamped between floor and ceiling.
// - Target gain uses an averaged RMS level, not single samples.
// - Loud signal lowers gain at attack rate, quiet raises at decay.
// - Attack rate from bits 15:12, doubling per code, 0 acts as 1.
// - Normal decay rate from bits 11:8, doubling per code.
// - Anti-clip looks ahead and speeds attack to stop output clipping.
// - Main register bit 1 enables anti-clip, reset value one.
// - Bit 5 selects a 5 or 9 sample main path delay.
// - With anti-clip off no look-ahead delay is inserted.
// - Main register bit 2 enables quick release; crest is always measured.
// - Crest above threshold swaps normal decay for quick decay.
// - Crest threshold from bits 7:6, 12 to 30 dB.
// - Quick decay rate from bits 5:4, 0.725, 1.45 or 5.8 ms.
// - On initialisation gain loads the start-up value first.
// - Start-up gain bits 10:6, -3 dB plus 0.5 dB per code.
// - Controller runs only with bit 15 set, never in pin mode.
// - Target level follows a two-slope curve around a knee.
`timescale 1ns/1ps
module adrg_gain_ctl #(
  parameter logic [31:0] DCY_TICK_CYC = adrg_pkg::DCY_TICK_DFLT
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic hw_mode_in,
  input wire logic [adrg_pkg::AVS_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [adrg_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid_in,
  output logic [adrg_pkg::SAMPLE_W-1:0] sample_out,
  output logic sample_valid_out
);
  import adrg_pkg::*;

  function automatic adrg_gain_t clamp_g(input adrg_gain_t v,
      input adrg_gain_t lo, input adrg_gain_t hi);
    clamp_g = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp_g

  logic [15:0] main_q;
  logic [15:0] time_q;
  logic [15:0] slope_q;
  logic [15:0] knee_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic hw_s1_q;
  logic hw_s2_q;
  logic run_q;
  adrg_gain_t gain_q;
  adrg_gain_t gain_d;
  adrg_dir_t dir_q;
  adrg_dir_t dir_d;
  logic [31:0] cnt_q;
  logic [31:0] period;
  logic [31:0] ms_q;
  logic [31:0] pk_q;
  logic [SAMPLE_W-1:0] dl_q [DELAY_LONG];
  logic [SAMPLE_W-1:0] sample_q;
  logic valid_q;

  // Register bus decode
  wire req = avs_read_in | avs_write_in;
  wire take = req & ~wait_q;
  wire [5:0] idx = avs_address_in[7:2];
  wire hit_main = idx == IDX_MAIN;
  wire hit_time = idx == IDX_TIME;
  wire hit_slope = idx == IDX_SLOPE;
  wire hit_knee = idx == IDX_KNEE;
  wire hit_stat = idx == IDX_STAT;
  wire wr_go = take & avs_write_in;
  wire [15:0] wmask = {{8{avs_byteenable_in[1]}},
    {8{avs_byteenable_in[0]}}};
  wire [15:0] wdat = avs_writedata_in[15:0] & wmask;
  wire [15:0] main_d = (main_q & ~wmask) | wdat;
  wire [15:0] time_d = (time_q & ~wmask) | wdat;
  wire [15:0] slope_d = (slope_q & ~wmask) | wdat;
  wire [15:0] knee_d = (knee_q & ~wmask) | wdat;

  // Field decode
  wire run = main_q[MAIN_EN_BIT] & ~hw_s2_q;
  wire init = run & ~run_q;
  wire clip_en = main_q[MAIN_AC_BIT];
  wire ff_long = main_q[MAIN_FF_BIT];
  wire qr_en = main_q[MAIN_QR_BIT];
  wire [4:0] su_code = main_q[MAIN_SU_LSB +: 5];
  wire [3:0] atk_code = time_q[TIME_ATK_LSB +: 4];
  wire [3:0] dcy_code = time_q[TIME_DCY_LSB +: 4];
  wire [1:0] thr_code = time_q[TIME_THR_LSB +: 2];
  wire [1:0] qrd_code = time_q[TIME_QRD_LSB +: 2];
  wire [1:0] min_code = time_q[TIME_MIN_LSB +: 2];
  wire [1:0] max_code = time_q[TIME_MAX_LSB +: 2];
  wire [2:0] hi_code = slope_q[SLOPE_HI_LSB +: 3];
  wire [2:0] lo_code = slope_q[SLOPE_LO_LSB +: 3];
  wire [5:0] kip_code = knee_q[KNEE_IP_LSB +: 6];
  wire [4:0] kop_code = knee_q[KNEE_OP_LSB +: 5];

  // Reserved codes fold onto the nearest defined one
  wire [3:0] atk_sh = (atk_code == 4'h0) ? 4'h0 :
    (atk_code > ATK_MAX_CODE) ? ATK_MAX_CODE - 4'h1 :
    atk_code - 4'h1;
  wire [3:0] dcy_sh = (dcy_code > DCY_MAX_CODE) ? DCY_MAX_CODE :
    dcy_code;
  wire [1:0] qr_sh = (qrd_code == 2'h0) ? 2'h0 :
    (qrd_code == 2'h1) ? 2'h1 : 2'h3;
  wire [4:0] su_c = (su_code > STARTUP_MAX_CODE) ?
    STARTUP_MAX_CODE : su_code;
  wire [5:0] kip_c = (kip_code > KNEE_IP_MAX) ? KNEE_IP_MAX :
    kip_code;
  wire [4:0] kop_c = (kop_code > KNEE_OP_MAX) ? KNEE_OP_MAX :
    kop_code;
  wire hi_zero = hi_code >= HI_ZERO_CODE;
  wire lo_zero = lo_code >= LO_ZERO_CODE;

  wire adrg_gain_t floor_g = adrg_gain_t'(-FLOOR_STEP *
    int'(min_code));
  wire adrg_gain_t ceil_g = CEIL_TBL[max_code];
  // Limits written in this cycle already bound the next gain value
  wire [15:0] time_nx = (wr_go && hit_time) ? time_d : time_q;
  wire adrg_gain_t floor_nx = adrg_gain_t'(-FLOOR_STEP *
    int'(time_nx[TIME_MIN_LSB +: 2]));
  wire adrg_gain_t ceil_nx = CEIL_TBL[time_nx[TIME_MAX_LSB +: 2]];
  wire adrg_gain_t thr_g = adrg_gain_t'(THR_BASE + THR_STEP *
    int'(thr_code));
  wire adrg_gain_t su_g = adrg_gain_t'(STARTUP_BASE +
    STARTUP_STEP * int'(su_c));
  wire adrg_gain_t knee_in = adrg_gain_t'(-KNEE_STEP *
    int'(kip_c));
  wire adrg_gain_t knee_out = adrg_gain_t'(-KNEE_STEP *
    int'(kop_c));

  // Level measurement from the undelayed input
  wire [SAMPLE_W-1:0] s_abs = sample_in[SAMPLE_W-1] ?
    SAMPLE_W'(-sample_in) : sample_in;
  wire [15:0] m16 = s_abs[SAMPLE_W-1 -: 16];
  wire [31:0] sq = m16 * m16;
  wire [31:0] pk_dec = pk_q - (pk_q >> PEAK_SHIFT);
  logic [10:0] att_rms;
  logic [10:0] att_pk;
  logic [10:0] att_now;

  adrg_level_log u_log_rms (
    .val_in(ms_q),
    .att_out(att_rms)
  );
  adrg_level_log u_log_pk (
    .val_in(pk_q),
    .att_out(att_pk)
  );
  adrg_level_log u_log_now (
    .val_in(sq),
    .att_out(att_now)
  );

  // Static curve around the knee gives the target gain
  wire adrg_gain_t lvl = -adrg_gain_t'(att_rms);
  wire above = lvl >= knee_in;
  wire adrg_gain_t dev = above ? lvl - knee_in : knee_in - lvl;
  wire adrg_gain_t dev_sc = above ?
    (hi_zero ? '0 : dev >>> hi_code) :
    (lo_zero ? '0 : dev >>> lo_code);
  wire adrg_gain_t t_out = above ? knee_out + dev_sc :
    knee_out - dev_sc;
  wire adrg_gain_t tgt = clamp_g(adrg_gain_t'(t_out - lvl),
    floor_g, ceil_g);

  // Crest factor and anti-clip prediction
  wire adrg_gain_t crest = adrg_gain_t'(att_rms) -
    adrg_gain_t'(att_pk);
  wire qr_act = qr_en & (crest > thr_g);
  // The next sample is seen before it reaches the output tap
  wire clip_risk = run & clip_en &
    (gain_q > adrg_gain_t'(att_now));

  always_comb begin
    if (clip_risk && gain_q > floor_g) begin
      dir_d = ST_ATTACK;
    end else if (gain_q > tgt) begin
      dir_d = ST_ATTACK;
    end else if (gain_q < tgt) begin
      dir_d = ST_DECAY;
    end else begin
      dir_d = ST_HOLD;
    end
  end

  always_comb begin
    unique case (dir_q)
      ST_ATTACK: begin
        period = clip_risk ? 32'h1 : ATK_TICK_CYC << atk_sh;
      end
      ST_DECAY: begin
        period = qr_act ? QR_TICK_CYC << qr_sh :
          DCY_TICK_CYC << dcy_sh;
      end
      ST_HOLD: begin
        period = '1;
      end
      default: begin
        period = '1;
      end
    endcase
  end

  wire same_dir = dir_d == dir_q;
  wire step = run & run_q & same_dir & (dir_q != ST_HOLD) &
    (cnt_q + 32'h1 >= period);

  always_comb begin
    if (init) begin
      gain_d = su_g;
    end else if (step && dir_q == ST_ATTACK) begin
      gain_d = gain_q - 12'sh001;
    end else if (step && dir_q == ST_DECAY) begin
      gain_d = gain_q + 12'sh001;
    end else begin
      gain_d = gain_q;
    end
    // Limits may change while running, so clamp every cycle
    gain_d = clamp_g(gain_d, floor_nx, ceil_nx);
  end

  // Gain to linear factor: octave shift times a table mantissa
  wire [11:0] gofs = 12'(gain_q + adrg_gain_t'(GAIN_OFS));
  wire [3:0] oct = 4'(gofs / 12'(STEPS_6DB));
  wire [11:0] rem = 12'(gofs - 12'(oct) * 12'(STEPS_6DB));
  wire [2:0] midx = 3'(rem / 12'(MANT_DIV));
  wire [8:0] mant = MANT_TBL[midx];

  // Look-ahead delay applies only while anti-clip is active
  wire [SAMPLE_W-1:0] tap = ff_long ? dl_q[DELAY_LONG-1] :
    dl_q[DELAY_SHORT-1];
  wire [SAMPLE_W-1:0] path_s = (run & clip_en) ? tap :
    sample_in;
  wire signed [33:0] prod = $signed(path_s) * $signed({1'b0, mant});
  wire signed [47:0] wide = (48'(prod) <<< oct) >>> LIN_SHIFT;
  wire sat_hi = wide > 48'sh0000007fffff;
  wire sat_lo = wide < -48'sh000000800000;
  wire [SAMPLE_W-1:0] scaled = sat_hi ? 24'h7fffff :
    sat_lo ? 24'h800000 : wide[SAMPLE_W-1:0];

  wire [15:0] stat_w = {2'h0, clip_risk, qr_act, gain_q};
  wire [15:0] rd_mux = hit_main ? main_q : hit_time ? time_q :
    hit_slope ? slope_q : hit_knee ? knee_q :
    hit_stat ? stat_w : 16'h0000;

  genvar gi;
  for (gi = 0; gi < DELAY_LONG; gi++) begin : g_dly
    wire [SAMPLE_W-1:0] src;
    if (gi == 0) begin : g_head
      assign src = sample_in;
    end else begin : g_tail
      assign src = dl_q[gi-1];
    end
    always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
        dl_q[gi] <= '0;
      end else if (sample_valid_in) begin
        dl_q[gi] <= src;
      end
    end
  end

  // Bus slave: one wait cycle, then a one-cycle answer
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
      main_q <= MAIN_RST;
      time_q <= TIME_RST;
      slope_q <= SLOPE_RST;
      knee_q <= KNEE_RST;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req && wait_q) begin
        rdata_q <= {16'h0000, rd_mux};
      end
      if (wr_go && hit_main) begin
        main_q <= main_d;
      end
      if (wr_go && hit_time) begin
        time_q <= time_d;
      end
      if (wr_go && hit_slope) begin
        slope_q <= slope_d;
      end
      if (wr_go && hit_knee) begin
        knee_q <= knee_d;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      hw_s1_q <= 1'b0;
      hw_s2_q <= 1'b0;
      run_q <= 1'b0;
      gain_q <= '0;
      dir_q <= ST_HOLD;
      cnt_q <= '0;
    end else begin
      hw_s1_q <= hw_mode_in;
      hw_s2_q <= hw_s1_q;
      run_q <= run;
      gain_q <= gain_d;
      dir_q <= run ? dir_d : ST_HOLD;
      cnt_q <= (!run || !same_dir || step) ? '0 : cnt_q + 32'h1;
    end
  end

  // Mean square and decaying peak, updated once per sample
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ms_q <= '0;
      pk_q <= '0;
    end else if (sample_valid_in) begin
      if (sq >= ms_q) begin
        ms_q <= ms_q + ((sq - ms_q) >> RMS_SHIFT);
      end else begin
        ms_q <= ms_q - ((ms_q - sq) >> RMS_SHIFT);
      end
      pk_q <= (sq > pk_dec) ? sq : pk_dec;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sample_q <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= sample_valid_in;
      if (sample_valid_in) begin
        sample_q <= run ? scaled : sample_in;
      end
    end
  end

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign sample_out = sample_q;
  assign sample_valid_out = valid_q;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_req_wait;
    req && wait_q;
  endsequence
  sequence s_answer;
    !wait_q ##1 wait_q;
  endsequence

  a_bus_answer:
    assert property (s_req_wait |=> s_answer)
    else $error("bus answer not one cycle");
  a_gain_floor:
    assert property (run && run_q |-> gain_q >= floor_g)
    else $error("gain below floor");
  a_gain_ceiling:
    assert property (run && run_q |-> gain_q <= ceil_g)
    else $error("gain above ceiling");
  a_target_clamp:
    assert property (tgt >= floor_g && tgt <= ceil_g)
    else $error("target outside limits");
  a_attack_step:
    assert property (step && dir_q == ST_ATTACK && !init &&
      gain_q > floor_g + 12'sh001 && $stable(time_q)
      |=> gain_q == $past(gain_q) - 12'sh001)
    else $error("attack step wrong");
  a_attack_rate:
    assert property (dir_q == ST_ATTACK && !clip_risk |->
      period == (ATK_TICK_CYC << atk_sh))
    else $error("attack period wrong");
  a_decay_rate:
    assert property (dir_q == ST_DECAY && !qr_act |->
      period == (DCY_TICK_CYC << dcy_sh))
    else $error("decay period wrong");
  a_clip_fast:
    assert property (clip_risk && dir_q == ST_ATTACK |->
      period == 32'h1)
    else $error("anti-clip not fast");
  a_quick_rate:
    assert property (dir_q == ST_DECAY && qr_act |->
      period == (QR_TICK_CYC << qr_sh))
    else $error("quick decay period wrong");
  a_init_load:
    assert property (init |=> gain_q == clamp_g($past(su_g),
      $past(floor_g), $past(ceil_g)))
    else $error("start-up gain not loaded");
  a_pin_mode:
    assert property (hw_s2_q |=> dir_q == ST_HOLD)
    else $error("controller ran in pin mode");
  a_bypass:
    assert property (sample_valid_in && !run |=>
      sample_out == $past(sample_in) && sample_valid_out)
    else $error("bypass sample wrong");
endmodule : adrg_gain_ctl

// *** verilog/adrg_pkg.sv ***
// Constants and types shared by the dynamic range gain block
package adrg_pkg;
  localparam int CLK_NS = 10;
  localparam int SAMPLE_W = 24;
  localparam int AVS_AW = 8;
  // Gain is counted in 0.125 dB steps
  localparam int STEPS_6DB = 48;
  typedef logic signed [11:0] adrg_gain_t;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_ATTACK = 3'b010,
    ST_DECAY = 3'b100
  } adrg_dir_t;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MAIN = 6'h20;
  localparam logic [5:0] IDX_TIME = 6'h21;
  localparam logic [5:0] IDX_SLOPE = 6'h22;
  localparam logic [5:0] IDX_KNEE = 6'h23;
  localparam logic [5:0] IDX_STAT = 6'h24;
  localparam int MAIN_EN_BIT = 15;
  localparam int MAIN_SU_LSB = 6;
  localparam int MAIN_FF_BIT = 5;
  localparam int MAIN_QR_BIT = 2;
  localparam int MAIN_AC_BIT = 1;
  localparam int TIME_ATK_LSB = 12;
  localparam int TIME_DCY_LSB = 8;
  localparam int TIME_THR_LSB = 6;
  localparam int TIME_QRD_LSB = 4;
  localparam int TIME_MIN_LSB = 2;
  localparam int TIME_MAX_LSB = 0;
  localparam int SLOPE_HI_LSB = 3;
  localparam int SLOPE_LO_LSB = 0;
  localparam int KNEE_IP_LSB = 5;
  localparam int KNEE_OP_LSB = 0;
  localparam logic [15:0] MAIN_RST = 16'h01a6;
  localparam logic [15:0] TIME_RST = 16'h4201;
  localparam logic [15:0] SLOPE_RST = 16'h0000;
  localparam logic [15:0] KNEE_RST = 16'h0000;
  // Time per 6 dB of the fastest code of each rate
  localparam int ATK_BASE_NS = 181000;
  localparam int DCY_BASE_NS = 186000000;
  localparam int QR_BASE_NS = 725000;
  localparam logic [31:0] ATK_TICK_CYC =
    32'(ATK_BASE_NS / CLK_NS / STEPS_6DB);
  localparam logic [31:0] QR_TICK_CYC =
    32'(QR_BASE_NS / CLK_NS / STEPS_6DB);
  localparam logic [31:0] DCY_TICK_DFLT =
    32'(DCY_BASE_NS / CLK_NS / STEPS_6DB);
  localparam logic [3:0] ATK_MAX_CODE = 4'hb;
  localparam logic [3:0] DCY_MAX_CODE = 4'h8;
  localparam int DELAY_SHORT = 5;
  localparam int DELAY_LONG = 9;
  localparam int RMS_SHIFT = 6;
  localparam int PEAK_SHIFT = 3;
  localparam int FLOOR_STEP = 48;
  localparam adrg_gain_t CEIL_TBL [4] =
    '{12'sd96, 12'sd144, 12'sd192, 12'sd288};
  localparam int THR_BASE = 96;
  localparam int THR_STEP = 48;
  localparam int STARTUP_BASE = -24;
  localparam int STARTUP_STEP = 4;
  localparam logic [4:0] STARTUP_MAX_CODE = 5'h12;
  localparam int KNEE_STEP = 6;
  localparam logic [5:0] KNEE_IP_MAX = 6'h3c;
  localparam logic [4:0] KNEE_OP_MAX = 5'h1e;
  localparam logic [2:0] HI_ZERO_CODE = 3'h5;
  localparam logic [2:0] LO_ZERO_CODE = 3'h4;
  // Level converter scaling, halved because it sees squares
  localparam int LOG_OCT_HALF = 24;
  localparam int LOG_MANT_HALF = 3;
  localparam logic [10:0] ATT_SILENT = 11'h2f8;
  // Linear gain: 2^(i/8) in 1/256 units, offset of four octaves
  localparam int GAIN_OFS = 192;
  localparam int MANT_DIV = 6;
  localparam int LIN_SHIFT = 12;
  localparam logic [8:0] MANT_TBL [8] = '{9'h100, 9'h117, 9'h130,
    9'h14c, 9'h16a, 9'h18b, 9'h1af, 9'h1d6};
endpackage : adrg_pkg

// *** verilog/adrg_level_log.sv ***
// Square-magnitude to level-below-full-scale converter
`timescale 1ns/1ps
module adrg_level_log (
  input wire logic [31:0] val_in,
  output logic [10:0] att_out
);
  import adrg_pkg::*;
  logic [4:0] pos;
  logic found;
  logic [31:0] norm;
  logic [2:0] mant;

  // Octave from the leading one, three bits below it refine it
  always_comb begin
    pos = '0;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!found && val_in[i]) begin
        pos = 5'(i);
        found = 1'b1;
      end
    end
    norm = val_in << (5'd31 - pos);
    mant = norm[30:28];
    if (!found) begin
      att_out = ATT_SILENT;
    end else begin
      // A full-scale sample squares to about 2^30, taken as 0 dB
      att_out = 11'((5'd30 - pos) * LOG_OCT_HALF)
        - 11'(mant * LOG_MANT_HALF);
    end
  end
endmodule : adrg_level_log

// *** test/adrg_testbench.sv ***
// Self-checking bench for the dynamic range gain controller
`timescale 1ns/1ps
module testbench;
  import adrg_pkg::*;
  localparam logic [31:0] DCY_SIM = 32'h4;
  logic clk, srst, hw_mode, rd, wr, svalid;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [23:0] sin, sout;
  logic waitreq, svalid_out;
  int n_errors, checks;

  adrg_gain_ctl #(.DCY_TICK_CYC(DCY_SIM)) dut (
    .core_clk_in(clk), .srst_in(srst), .hw_mode_in(hw_mode),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .sample_in(sin), .sample_valid_in(svalid),
    .sample_out(sout), .sample_valid_out(svalid_out));

  initial begin
    clk = 1'b0;
    forever #(CLK_NS / 2) clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic is_wr, input logic [7:0] a,
      input logic [15:0] d, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= {16'h0000, d};
    rd <= ~is_wr;
    wr <= is_wr;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    check("rd_upper", q & 32'hffff0000, 32'h0);
  endtask : bus

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 16'h0000, q);
  endtask : rd_reg

  task automatic chk_gain(input string name, input int exp);
    logic [31:0] q;
    rd_reg(8'h90, q);
    check(name, {20'h0, q[11:0]}, {20'h0, 12'(exp)});
  endtask : chk_gain

  // One sample in, its answer taken in the cycle after it was taken
  task automatic send(input logic [23:0] s, output logic [23:0] o);
    @(posedge clk);
    sin <= s;
    svalid <= 1'b1;
    @(posedge clk);
    svalid <= 1'b0;
    @(posedge clk);
    check("valid_out", {31'h0, svalid_out}, 32'h1);
    o = sout;
  endtask : send

  task automatic t_reset_values;
    logic [31:0] q;
    rd_reg(8'h80, q);
    check("main_rst", q, 32'h000001a6);
    rd_reg(8'h84, q);
    check("time_rst", q, 32'h00004201);
    wr_reg(8'hfc, 16'hffff);
    rd_reg(8'hfc, q);
    check("unmapped", q, 32'h0);
    wr_reg(8'h90, 16'h0fff);
    chk_gain("status_ro", 0);
  endtask : t_reset_values

  // Pin mode blocks the controller; releasing it starts initialisation
  task automatic t_pin_mode;
    logic [23:0] o;
    hw_mode <= 1'b1;
    wr_reg(8'h84, 16'h480d);
    wr_reg(8'h80, 16'h8000 | (16'd18 << 6) | 16'h0026);
    repeat (8) @(posedge clk);
    chk_gain("pin_gain", 0);
    send(24'h123456, o);
    check("pin_raw", {8'h0, o}, 32'h00123456);
    hw_mode <= 1'b0;
    repeat (5) @(posedge clk);
    chk_gain("pin_release", 48);
  endtask : t_pin_mode

  task automatic t_startup;
    int codes[4] = '{0, 6, 18, 31};
    int c;
    foreach (codes[i]) begin
      c = codes[i];
      wr_reg(8'h80, 16'h0026);
      wr_reg(8'h80, 16'h8000 | 16'(c << 6) | 16'h0026);
      c = (c > 18) ? 18 : c;
      chk_gain("startup", STARTUP_BASE + STARTUP_STEP * c);
    end
  endtask : t_startup

  task automatic t_delay;
    logic [15:0] modes[3] = '{16'h8186, 16'h81a6, 16'h8184};
    int dly[3] = '{DELAY_SHORT, DELAY_LONG, 0};
    logic [23:0] o;
    foreach (modes[m]) begin
      wr_reg(8'h80, modes[m]);
      repeat (10) send(24'h000000, o);
      for (int k = 0; k <= 10; k++) begin
        send((k == 0) ? 24'h100000 : 24'h000000, o);
        check("delay_out", {31'h0, (o != 24'h0)},
          {31'h0, k == dly[m]});
      end
    end
  endtask : t_delay

  // Silence drives the gain up until the ceiling stops it
  task automatic t_ceiling;
    logic [23:0] o;
    // Lower slope zero makes a quiet input ask for a large boost
    wr_reg(8'h88, 16'h0004);
    repeat (128) send(24'h000000, o);
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h84, 16'h4000 | 16'(c));
      wr_reg(8'h80, 16'h01a6);
      wr_reg(8'h80, 16'h81a6);
      repeat (2000) @(posedge clk);
      chk_gain("ceiling", int'(CEIL_TBL[c]));
    end
  endtask : t_ceiling

  // A half-scale sample leaves 6 dB headroom; anti-clip pulls gain to it
  task automatic t_clip;
    wr_reg(8'h84, 16'h4803);
    sin <= 24'h400000;
    repeat (500) @(posedge clk);
    chk_gain("clip_guard", STEPS_6DB);
    sin <= 24'h000000;
  endtask : t_clip

  // Loud input against a flat curve pulls the gain down to the floor
  task automatic t_floor;
    logic [23:0] o;
    wr_reg(8'h88, 16'h0028);
    wr_reg(8'h8c, 16'h079e);
    wr_reg(8'h84, 16'h1804);
    wr_reg(8'h80, 16'h01a6);
    wr_reg(8'h80, 16'h81a6);
    repeat (9000) send(24'h7fffff, o);
    chk_gain("floor", -FLOOR_STEP);
  endtask : t_floor

  initial begin
    n_errors = 0;
    checks = 0;
    srst = 1'b1;
    hw_mode = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    be = 4'hf;
    sin = 24'h0;
    svalid = 1'b0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset_values;
    t_pin_mode;
    t_startup;
    t_delay;
    t_ceiling;
    t_clip;
    t_floor;
    results;
  end

  // Whole run is some 40000 cycles; far beyond that means a hang
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    results;
  end
endmodule : testbench
